// File: logic/ch3_io_ctrl.sv
// Purpose: channel 3 registers B/C/D input capture and output compare control
// Assumes: APB slave, 100 MHz pclk, counter and match strobes from the channel
// Notes: one interrupt level, sticky status with write-one clear register
//
// Implementation choices: the APB register port and the register offsets.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Function
// - 0001/0010/0011: start low; match drives low, high, toggles
// - 0101/0110/0111: start high; match drives low, high, toggles
// - 1000 rising, 1001 falling, 101x both edges capture counter
// - pin capture uses each register's own channel 3 pin
// - 11xx captures on every channel 4 count event
// - channel 4 on undivided clock: count capture invalid
// - buffer mode a: register c setting ignored, no events
// - buffer mode b: register d setting ignored, no events
// - c/d io register: d field bits 7-4, c bits 3-0, reset zero
// - enable bit gates conversion start request
module ch3_io_ctrl
  import ch3_io_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire ch3_io_pkg::counter_if_t ch4_counter,
  input wire logic [2:0] match_in,
  input wire logic ch3_pin_b_in,
  input wire logic ch3_pin_c_in,
  input wire logic ch3_pin_d_in,
  output logic ch3_pin_b_out,
  output logic ch3_pin_c_out,
  output logic ch3_pin_d_out,
  output logic ch3_pin_b_oe,
  output logic ch3_pin_c_oe,
  output logic ch3_pin_d_oe,
  output logic adc_start_req,
  output logic irq
);
  import ch3_io_pkg::*;

  logic [7:0] b_io_r, b_io_nxt;
  logic [7:0] ch3_cd_io_control_r, ch3_cd_io_control_nxt;
  logic [7:0] ctrl_r, ctrl_nxt;
  logic [NEV-1:0] status_r, status_nxt, enable_r, enable_nxt;
  logic [31:0] prdata_nxt;
  logic pslverr_nxt, irq_nxt, adc_nxt, pready_r;
  logic access, wr, mapped;
  logic [NCH-1:0] ev, wr_greg, pin_in, buf_sel, pin_out, pin_oe;
  logic [3:0] fld [NCH];
  logic [15:0] greg [NCH];
  logic psc_undivided;

  ////////////////////////////////////////////////////////////////////////////
  // decode of register settings
  always_comb begin
    fld[0] = b_io_r[7:4];
    fld[1] = ch3_cd_io_control_r[REG_C_FIELD_LSB +: 4];
    fld[2] = ch3_cd_io_control_r[REG_D_FIELD_LSB +: 4];
    buf_sel = {ctrl_r[CTRL_BUF_B_BIT], ctrl_r[CTRL_BUF_A_BIT], 1'b0};
    pin_in = {ch3_pin_d_in, ch3_pin_c_in, ch3_pin_b_in};
    psc_undivided = (ctrl_r[CTRL_PSC_LSB +: 3] == PSC_UNDIVIDED);
  end

  assign access = psel & penable & pready_r;
  assign wr = access & pwrite;

  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_unit
      localparam logic [7:0] GADDR = ADDR_REG_B + 8'(4 * gi);
      assign wr_greg[gi] = wr && paddr == GADDR;
      ch3_io_unit u_unit (
        .pclk(pclk),
        .presetn(presetn),
        .field(fld[gi]),
        .buffered(buf_sel[gi]),
        .psc_undivided(psc_undivided),
        .pin_in(pin_in[gi]),
        .match(match_in[gi]),
        .cnt(ch4_counter),
        .wr_en(wr_greg[gi]),
        .wr_data(pwdata[15:0]),
        .greg_r(greg[gi]),
        .pin_out_r(pin_out[gi]),
        .pin_oe_r(pin_oe[gi]),
        .event_r(ev[gi])
      );
    end
  endgenerate

  assign ch3_pin_b_out = pin_out[0];
  assign ch3_pin_c_out = pin_out[1];
  assign ch3_pin_d_out = pin_out[2];
  assign ch3_pin_b_oe = pin_oe[0];
  assign ch3_pin_c_oe = pin_oe[1];
  assign ch3_pin_d_oe = pin_oe[2];

  ////////////////////////////////////////////////////////////////////////////
  // register file and apb answers
  always_comb begin
    b_io_nxt = b_io_r;
    ch3_cd_io_control_nxt = ch3_cd_io_control_r;
    ctrl_nxt = ctrl_r;
    enable_nxt = enable_r;
    status_nxt = status_r;
    prdata_nxt = prdata;
    pslverr_nxt = 1'b0;
    mapped = 1'b1;
    case (paddr)
      ADDR_B_IO, ADDR_CD_IO, ADDR_CTRL, ADDR_STATUS, ADDR_CLEAR, ADDR_ENABLE,
      ADDR_REG_B, ADDR_REG_C, ADDR_REG_D: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
    // answers launched at setup, standing through access
    if (psel && !penable) begin
      pslverr_nxt = ~mapped;
      prdata_nxt = 32'h0000_0000;
      if (!pwrite) begin
        case (paddr)
          ADDR_B_IO: prdata_nxt = {24'h000000, b_io_r};
          ADDR_CD_IO: prdata_nxt = {24'h000000, ch3_cd_io_control_r};
          ADDR_CTRL: prdata_nxt = {24'h000000, ctrl_r};
          ADDR_STATUS: prdata_nxt = {29'h0, status_r};
          ADDR_ENABLE: prdata_nxt = {29'h0, enable_r};
          ADDR_REG_B: prdata_nxt = {16'h0000, greg[0]};
          ADDR_REG_C: prdata_nxt = {16'h0000, greg[1]};
          ADDR_REG_D: prdata_nxt = {16'h0000, greg[2]};
          default: prdata_nxt = 32'h0000_0000;
        endcase
      end
    end
    if (wr) begin
      case (paddr)
        ADDR_B_IO: b_io_nxt = pwdata[7:0];
        ADDR_CD_IO: ch3_cd_io_control_nxt = pwdata[7:0];
        ADDR_CTRL: ctrl_nxt = pwdata[7:0];
        ADDR_ENABLE: enable_nxt = pwdata[NEV-1:0];
        ADDR_CLEAR: status_nxt = status_r & ~pwdata[NEV-1:0];
        default: status_nxt = status_r;
      endcase
    end
    // set wins over clear
    status_nxt = status_nxt | ev;
    irq_nxt = |(status_nxt & enable_nxt);
    adc_nxt = ctrl_r[CTRL_ADC_EN_BIT] & ev[0];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      b_io_r <= IO_RESET;
      ch3_cd_io_control_r <= IO_RESET;
      ctrl_r <= 8'h00;
      status_r <= '0;
      enable_r <= '0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
      pready_r <= 1'b1;
      irq <= 1'b0;
      adc_start_req <= 1'b0;
    end else begin
      b_io_r <= b_io_nxt;
      ch3_cd_io_control_r <= ch3_cd_io_control_nxt;
      ctrl_r <= ctrl_nxt;
      status_r <= status_nxt;
      enable_r <= enable_nxt;
      prdata <= prdata_nxt;
      pslverr <= pslverr_nxt;
      pready_r <= 1'b1;
      irq <= irq_nxt;
      adc_start_req <= adc_nxt;
    end
  end

  assign pready = pready_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  // pin c rising edge under rising capture
  sequence s_c_rise;
    fld[1] == 4'h8 && !buf_sel[1] && ch3_pin_c_in && !$past(ch3_pin_c_in);
  endsequence
  // pin c falling edge under falling capture
  sequence s_c_fall;
    fld[1] == 4'h9 && !buf_sel[1] && !ch3_pin_c_in && $past(ch3_pin_c_in);
  endsequence
  // pin c change under both-edge capture
  sequence s_c_any_edge;
    fld[1][3:1] == 3'b101 && !buf_sel[1] && ch3_pin_c_in != $past(ch3_pin_c_in);
  endsequence
  // channel 4 count event under d count capture
  sequence s_d_tick;
    fld[2][3:2] == 2'b11 && !buf_sel[2] && ch4_counter.cnt_tick;
  endsequence
  // b newly set to an enabled output code
  sequence s_b_new_out;
    fld[0][3] == 1'b0 && fld[0][1:0] != 2'b00 && $changed(fld[0]);
  endsequence
  // b held at one code while a match arrives
  sequence s_b_match;
    fld[0][3] == 1'b0 && $stable(fld[0]) && match_in[0];
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  // pin output checks
  // disabled codes
  a_out_disabled: assert property (@(posedge pclk) disable iff (!presetn)
    (fld[0][3] == 1'b0 && fld[0][1:0] == 2'b00) |=> !ch3_pin_b_oe)
    else $error("disabled code drives pin b");
  a_out_enabled: assert property (@(posedge pclk) disable iff (!presetn)
    (fld[0][3] == 1'b0 && fld[0][1:0] != 2'b00) |=> ch3_pin_b_oe)
    else $error("output code leaves pin b undriven");
  a_init_level: assert property (@(posedge pclk) disable iff (!presetn)
    s_b_new_out |=> ch3_pin_b_out == $past(fld[0][2]))
    else $error("initial level missed");
  a_low_match: assert property (@(posedge pclk) disable iff (!presetn)
    s_b_match ##0 fld[0][1:0] == 2'b01 |=> !ch3_pin_b_out)
    else $error("low on match missed");
  a_high_match: assert property (@(posedge pclk) disable iff (!presetn)
    s_b_match ##0 fld[0][1:0] == 2'b10 |=> ch3_pin_b_out)
    else $error("high on match missed");
  a_toggle_match: assert property (@(posedge pclk) disable iff (!presetn)
    s_b_match ##0 fld[0][1:0] == 2'b11 |=> ch3_pin_b_out != $past(ch3_pin_b_out))
    else $error("toggle missed");

  ////////////////////////////////////////////////////////////////////////////
  // capture checks
  // rising edge capture
  a_rise_capture: assert property (@(posedge pclk) disable iff (!presetn)
    s_c_rise |=> ev[1] && greg[1] == $past(ch4_counter.count))
    else $error("rising capture missed");
  a_fall_capture: assert property (@(posedge pclk) disable iff (!presetn)
    s_c_fall |=> ev[1] && greg[1] == $past(ch4_counter.count))
    else $error("falling capture missed");
  a_both_capture: assert property (@(posedge pclk) disable iff (!presetn)
    s_c_any_edge |=> ev[1])
    else $error("both edge capture missed");
  a_cnt_capture: assert property (@(posedge pclk) disable iff (!presetn)
    s_d_tick ##0 !psc_undivided |=> ev[2] && greg[2] == $past(ch4_counter.count))
    else $error("count capture missed");
  a_undiv_no_cap: assert property (@(posedge pclk) disable iff (!presetn)
    s_d_tick ##0 psc_undivided |=> !ev[2])
    else $error("capture on undivided clock");

  ////////////////////////////////////////////////////////////////////////////
  // buffer checks
  // buffered c silent
  a_buf_c_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    $past(buf_sel[1]) && buf_sel[1] |=> !ch3_pin_c_oe)
    else $error("buffered c drives pin");
  a_buf_c_events: assert property (@(posedge pclk) disable iff (!presetn)
    buf_sel[1] |=> !ev[1])
    else $error("buffered c produced event");
  a_buf_d_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    buf_sel[2] |=> !ev[2])
    else $error("buffered d produced event");
  a_buf_d_pin: assert property (@(posedge pclk) disable iff (!presetn)
    buf_sel[2] |=> !ch3_pin_d_oe)
    else $error("buffered d drives pin");

  ////////////////////////////////////////////////////////////////////////////
  // register and interrupt checks
  // request gated
  a_adc_gate: assert property (@(posedge pclk) disable iff (!presetn)
    !ctrl_r[CTRL_ADC_EN_BIT] |=> !adc_start_req)
    else $error("request while disabled");
  a_adc_follow: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_r[CTRL_ADC_EN_BIT] && ev[0] |=> adc_start_req)
    else $error("request missed");
  a_event_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    ev[0] |=> status_r[0])
    else $error("event flag not set");
  a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
    irq == |(status_r & enable_r))
    else $error("irq mismatch");
endmodule

// File: logic/ch3_io_pkg.sv
// Purpose: shared constants and types for the channel 3 B/C/D capture/compare control
// Assumes: 32-bit APB, one aligned word per register
// Notes: offsets below are byte addresses
package ch3_io_pkg;
  localparam logic [7:0] ADDR_B_IO = 8'h00;
  localparam logic [7:0] ADDR_CD_IO = 8'h04;
  localparam logic [7:0] ADDR_CTRL = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_CLEAR = 8'h10;
  localparam logic [7:0] ADDR_ENABLE = 8'h14;
  localparam logic [7:0] ADDR_REG_B = 8'h18;
  localparam logic [7:0] ADDR_REG_C = 8'h1C;
  localparam logic [7:0] ADDR_REG_D = 8'h20;
  localparam logic [7:0] IO_RESET = 8'h00;
  localparam int REG_D_FIELD_LSB = 4;
  localparam int REG_C_FIELD_LSB = 0;
  localparam int CTRL_BUF_A_BIT = 0;
  localparam int CTRL_BUF_B_BIT = 1;
  localparam int CTRL_ADC_EN_BIT = 2;
  localparam int CTRL_PSC_LSB = 4;
  localparam logic [2:0] PSC_UNDIVIDED = 3'h0;
  localparam logic [15:0] GREG_RESET = 16'hFFFF;
  localparam int NCH = 3;
  // event bits: 0..2 capture/compare b,c,d
  localparam int NEV = 3;

  typedef enum logic [1:0] {
    ACT_OFF,
    ACT_OUT,
    ACT_PIN_CAP,
    ACT_CNT_CAP
  } act_t;

  typedef struct packed {
    logic cnt_tick;
    logic [15:0] count;
  } counter_if_t;
endpackage

// File: logic/ch3_io_unit.sv
// Purpose: one general register with its field decode, pin output and capture
// Assumes: pin inputs synchronous to pclk
// Notes: counter and compare match come from the channel outside
`timescale 1ns/1ps
module ch3_io_unit
  import ch3_io_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [3:0] field,
  input wire logic buffered,
  input wire logic psc_undivided,
  input wire logic pin_in,
  input wire logic match,
  input wire ch3_io_pkg::counter_if_t cnt,
  input wire logic wr_en,
  input wire logic [15:0] wr_data,
  output logic [15:0] greg_r,
  output logic pin_out_r,
  output logic pin_oe_r,
  output logic event_r
);
  logic pin_prev_r, pin_prev_nxt;
  logic [3:0] field_prev_r;
  logic [15:0] greg_nxt;
  logic pin_out_nxt, pin_oe_nxt, event_nxt;
  act_t act;
  logic rise, fall, cap;

  always_comb begin
    act = ACT_OFF;
    if (buffered) begin
      act = ACT_OFF;
    end else if (field[3] == 1'b0) begin
      act = (field[1:0] == 2'b00) ? ACT_OFF : ACT_OUT;
    end else begin
      act = field[2] ? ACT_CNT_CAP : ACT_PIN_CAP;
    end
    rise = pin_in & ~pin_prev_r;
    fall = ~pin_in & pin_prev_r;
    cap = 1'b0;
    case (act)
      ACT_PIN_CAP: cap = field[1] ? (rise | fall) : (field[0] ? fall : rise);
      ACT_CNT_CAP: cap = cnt.cnt_tick & ~psc_undivided;
      default: cap = 1'b0;
    endcase
    pin_prev_nxt = pin_in;
    greg_nxt = greg_r;
    if (wr_en) begin
      greg_nxt = wr_data;
    end
    if (cap) begin
      greg_nxt = cnt.count;
    end
    pin_oe_nxt = (act == ACT_OUT);
    pin_out_nxt = pin_out_r;
    if (act == ACT_OUT && field != field_prev_r) begin
      pin_out_nxt = field[2];
    end else if (act == ACT_OUT && match) begin
      case (field[1:0])
        2'b01: pin_out_nxt = 1'b0;
        2'b10: pin_out_nxt = 1'b1;
        2'b11: pin_out_nxt = ~pin_out_r;
        default: pin_out_nxt = pin_out_r;
      endcase
    end
    if (act == ACT_OFF) begin
      pin_out_nxt = 1'b0;
    end
    event_nxt = cap | (act == ACT_OUT && match) | (act == ACT_OFF && !buffered && match);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      greg_r <= GREG_RESET;
      pin_out_r <= 1'b0;
      pin_oe_r <= 1'b0;
      event_r <= 1'b0;
      pin_prev_r <= 1'b0;
      field_prev_r <= 4'h0;
    end else begin
      greg_r <= greg_nxt;
      pin_out_r <= pin_out_nxt;
      pin_oe_r <= pin_oe_nxt;
      event_r <= event_nxt;
      pin_prev_r <= pin_prev_nxt;
      field_prev_r <= buffered ? 4'h0 : field;
    end
  end
endmodule

// File: tb/far_side.sv
// Purpose: channel 4 counter model feeding count and tick
// Assumes: one pclk domain
// Notes: advances one count every four cycles while run is high
`timescale 1ns/1ps
module far_side
  import ch3_io_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  output ch3_io_pkg::counter_if_t cnt
);
  logic [1:0] div_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r <= 2'h0;
      cnt <= '0;
    end else begin
      div_r <= run ? div_r + 2'h1 : 2'h0;
      cnt.cnt_tick <= run && div_r == 2'h3;
      cnt.count <= cnt.count + {15'h0000, run && div_r == 2'h3};
    end
  end
endmodule

// File: tb/tb.sv
// Purpose: self-checking bench for channel 3 b/c/d control
// Assumes: zero wait state apb, counter from far_side
// Notes: random values from a fixed seed
`timescale 1ns/1ps
module tb;
  import ch3_io_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, run = 1'b0, serr;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q, v;
  logic pready, pslverr, adc_start_req, irq;
  logic [2:0] match_in = 3'h0, pin_in = 3'h0, pin_out, pin_oe;
  counter_if_t cnt;
  int errors = 0, num_checks = 0, adc_seen = 0;
  always #5 pclk = ~pclk;
  always @(posedge pclk) if (adc_start_req === 1'b1) adc_seen++;
  far_side FS (.pclk(pclk), .presetn(presetn), .run(run), .cnt(cnt));
  ch3_io_ctrl DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ch4_counter(cnt), .match_in(match_in),
    .ch3_pin_b_in(pin_in[0]), .ch3_pin_c_in(pin_in[1]), .ch3_pin_d_in(pin_in[2]), .ch3_pin_b_out(pin_out[0]),
    .ch3_pin_c_out(pin_out[1]), .ch3_pin_d_out(pin_out[2]), .ch3_pin_b_oe(pin_oe[0]), .ch3_pin_c_oe(pin_oe[1]),
    .ch3_pin_d_oe(pin_oe[2]), .adc_start_req(adc_start_req), .irq(irq));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t %s: got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic count_for(input int n);
    @(posedge pclk);
    run <= 1'b1;
    cyc(n);
    run <= 1'b0;
    cyc(3);
  endtask
  task automatic hit(input logic [2:0] m);
    @(posedge pclk);
    match_in <= m;
    @(posedge pclk);
    match_in <= 3'h0;
    cyc(3);
  endtask
  task automatic pin_set(input int i, input logic l);
    @(posedge pclk);
    pin_in[i] <= l;
    cyc(3);
  endtask
  function automatic logic pin_exp(input logic [3:0] f, input int n);
    logic l;
    l = f[2];
    for (int i = 0; i < n; i++) l = (f[1:0] == 2'h3) ? ~l : (f[1:0] == 2'h2);
    return l;
  endfunction
  task automatic report_and_stop;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #300000;
    errors++;
    $display("[ERR] %0t watchdog", $time);
    report_and_stop();
  end
  initial begin
    logic [3:0] f;
    logic [15:0] prev;
    int n;
    void'($urandom(32'h89DE));
    cyc(6);
    presetn <= 1'b1;
    rd(ADDR_CD_IO);
    chk(q, 32'h0, "cd reset");
    v = {24'h0, 8'($urandom)};
    wr(ADDR_CD_IO, v);
    rd(ADDR_CD_IO);
    chk(q, v, "cd readback");
    $display("test registers done");
    for (int c = 0; c < 8; c++) begin
      f = 4'(c);
      wr(ADDR_B_IO, {24'h0, f, 4'h0});
      cyc(2);
      chk(pin_oe[0], f[1:0] != 2'h0, "oe");
      chk(pin_out[0], f[1:0] != 2'h0 && f[2], "initial");
      n = 1 + $urandom % 3;
      repeat (n) hit(3'h1);
      chk(pin_out[0], f[1:0] != 2'h0 && pin_exp(f, n), "match");
    end
    $display("test compare done");
    wr(ADDR_CD_IO, 32'h0);
    prev = GREG_RESET;
    for (int c = 8; c < 11; c++) begin
      wr(ADDR_CD_IO, 32'(c));
      count_for(4 + $urandom % 20);
      pin_set(1, 1'b1);
      if (c != 9) prev = cnt.count;
      rd(ADDR_REG_C);
      chk(q, prev, "rise");
      count_for(4 + $urandom % 20);
      pin_set(1, 1'b0);
      if (c != 8) prev = cnt.count;
      rd(ADDR_REG_C);
      chk(q, prev, "fall");
      count_for(8);
      pin_set(0, ~pin_in[0]);
      rd(ADDR_REG_C);
      chk(q, prev, "other pin");
    end
    $display("test pin capture done");
    wr(ADDR_CD_IO, 32'hC0);
    rd(ADDR_REG_D);
    prev = q[15:0];
    count_for(20);
    rd(ADDR_REG_D);
    chk(q, prev, "undivided");
    wr(ADDR_CTRL, 32'h10);
    count_for(20);
    rd(ADDR_REG_D);
    chk(q, cnt.count, "count capture");
    $display("test count capture done");
    wr(ADDR_CTRL, 32'h13);
    wr(ADDR_CD_IO, 32'hC8);
    wr(ADDR_CLEAR, 32'h7);
    rd(ADDR_REG_C);
    v = q;
    rd(ADDR_REG_D);
    prev = q[15:0];
    count_for(20);
    pin_set(1, 1'b1);
    hit(3'h6);
    rd(ADDR_REG_C);
    chk(q, v, "buffer c");
    rd(ADDR_REG_D);
    chk(q, prev, "buffer d");
    rd(ADDR_STATUS);
    chk(q & 32'h6, 32'h0, "buffer events");
    $display("test buffer done");
    wr(ADDR_CTRL, 32'h10);
    wr(ADDR_B_IO, 32'h10);
    wr(ADDR_CLEAR, 32'h7);
    wr(ADDR_ENABLE, 32'h1);
    adc_seen = 0;
    hit(3'h1);
    chk(irq, 1'b1, "irq");
    chk(adc_seen, 0, "adc off");
    wr(ADDR_ENABLE, 32'h0);
    cyc(2);
    chk(irq, 1'b0, "masked");
    wr(ADDR_ENABLE, 32'h1);
    wr(ADDR_CLEAR, 32'h6);
    rd(ADDR_STATUS);
    chk(q[0], 1'b1, "kept");
    wr(ADDR_CLEAR, 32'h1);
    rd(ADDR_STATUS);
    chk(q[0], 1'b0, "cleared");
    chk(irq, 1'b0, "irq low");
    wr(ADDR_CTRL, 32'h14);
    adc_seen = 0;
    hit(3'h1);
    chk(adc_seen, 1, "adc on");
    wr(ADDR_CD_IO, 32'h57);
    cyc(2);
    chk(pin_oe[2:1], 2'h3, "cd oe");
    chk(pin_out[2:1], 2'h3, "cd initial");
    hit(3'h6);
    chk(pin_out[2:1], 2'h0, "cd match");
    wr(ADDR_CTRL, 32'h13);
    cyc(2);
    chk(pin_oe[2:1], 2'h0, "cd buffered");
    wr(8'hFC, 32'hFFFFFFFF);
    chk(serr, 1'b1, "unmapped err");
    rd(8'hFC);
    chk(q, 32'h0, "unmapped rd");
    $display("test irq done");
    report_and_stop();
  end
endmodule
